// ===== common/isrc_pkg.sv
// Constants and types of the interface and sub-reset control block
package isrc_pkg;

   //------------------------------------------------------------------
   // Widths
   //------------------------------------------------------------------
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 8;
   localparam int N_UNITS = 8;
   localparam int SYNC_N  = 3;

   //------------------------------------------------------------------
   // Register offsets
   //------------------------------------------------------------------
   localparam logic [7:0] OFS_MAIN     = 8'h00;
   localparam logic [7:0] OFS_IFACE    = 8'h01;
   localparam logic [7:0] OFS_SOFT_RST = 8'h02;
   localparam logic [7:0] OFS_SEQ      = 8'h03;
   localparam logic [7:0] OFS_TEST     = 8'h10;
   localparam logic [7:0] OFS_RST_DONE = 8'h41;

   //------------------------------------------------------------------
   // Reset values
   //------------------------------------------------------------------
   localparam logic [7:0] RST_MAIN     = 8'h01;
   localparam logic [7:0] RST_IFACE    = 8'h00;
   localparam logic [7:0] RST_SOFT_RST = 8'h00;
   localparam logic [7:0] RST_SEQ      = 8'h8A;
   localparam logic [7:0] RST_TEST     = 8'h00;

   //------------------------------------------------------------------
   // Field positions
   //------------------------------------------------------------------
   localparam int MAIN_RXTX      = 7;
   localparam int MAIN_PD_HI     = 5;
   localparam int MAIN_PD_LO     = 4;
   localparam int MAIN_RESET_LOW = 0;
   localparam int IF_OSC_BYPASS  = 7;
   localparam int IF_SEP_RX_OUT  = 6;
   localparam int IF_GATE_LOCK   = 5;
   localparam int IF_GATE_CS     = 4;
   localparam int IF_AMP_CTRL    = 3;
   localparam int IF_LNA_CTRL    = 2;
   localparam int IF_AMP_POL     = 1;
   localparam int IF_LNA_POL     = 0;
   localparam int IF_ANALOG_TEST_POWER_DOWN     = 3;
   localparam int IF_TEST_MD_HI  = 2;
   localparam int IF_TEST_MD_LO  = 0;
   localparam int SEQ_SELECT_SRC = 7;
   localparam int TEST_FILTER_EN = 1;
   localparam int TEST_ANALOG_EN = 0;

   //------------------------------------------------------------------
   // Test defaults and power-down modes
   //------------------------------------------------------------------
   localparam logic       ANALOG_TEST_POWER_DOWN_IDLE   = 1'b1;
   localparam logic [2:0] TEST_MODE_IDLE = 3'h1;

   typedef enum logic [1:0] {
      PD_SPLIT = 2'b00,
      PD_BOTH  = 2'b01,
      PD_INDIV = 2'b10,
      PD_AUTO  = 2'b11
   } isrc_power_down_mode_t;

endpackage : isrc_pkg

// ===== common/isrc_rst_if.sv
// Signals between the register bank and the sub-reset sequencer
`timescale 1ns/1ns
interface isrc_rst_if;
   logic [7:0] req;
   logic [7:0] clk_run;
   logic       load_all;
   logic [7:0] unit_rst_low;
   logic [7:0] started;
   logic [7:0] done;

   modport ctrl (output req, clk_run, load_all,
                 input  unit_rst_low, started, done);
   modport unit (input  req, clk_run, load_all,
                 output unit_rst_low, started, done);
endinterface : isrc_rst_if

// ===== rtl/isrc_subreset.sv
// Self-clearing sub-reset sequencer for the digital units
`timescale 1ns/1ns
module isrc_subreset
   import isrc_pkg::*;
(
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // Bank side
   isrc_rst_if.unit rst
);

   //------------------------------------------------------------------
   // Pending and active state per unit
   //------------------------------------------------------------------
   logic [N_UNITS-1:0] pending;
   logic [N_UNITS-1:0] next_pending;
   logic [N_UNITS-1:0] active;
   logic [N_UNITS-1:0] next_active;
   logic [N_UNITS-1:0] start_now;
   logic [N_UNITS-1:0] stall_now;

   assign start_now = pending & rst.clk_run;
   assign stall_now = active & ~rst.clk_run;

   always_comb begin
      // Start only with the unit clock running, else keep waiting
      next_active  = stall_now | start_now;
      // New request keeps the bit pending even when it starts in the same cycle
      next_pending = (pending & ~rst.clk_run) | rst.req
                     | {N_UNITS{rst.load_all}};
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         pending <= ~RST_SOFT_RST;
         active  <= '0;
      end else if (i_ce) begin
         pending <= next_pending;
         active  <= next_active;
      end
   end

   assign rst.unit_rst_low = ~active;
   assign rst.started      = ~pending;
   assign rst.done         = ~(pending | active);

   //------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------
   a_start_sets_bit: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && rst.req == '0 && !rst.load_all && start_now != '0)
      |=> ((rst.started & $past(start_now)) == $past(start_now))
   ) else $error("Reset bit did not return to one on start");

   a_stall_holds_rst: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && stall_now != '0)
      |=> ((rst.unit_rst_low & $past(stall_now)) == '0)
   ) else $error("Unit reset released without its clock");

   a_request_kept: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && rst.req != '0)
      |=> ((rst.started & $past(rst.req)) == '0)
   ) else $error("Sub-reset request was lost");

   a_start_asserts: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && start_now != '0)
      |=> ((rst.unit_rst_low & $past(start_now)) == '0)
   ) else $error("Started unit reset not asserted");

endmodule : isrc_subreset

// ===== rtl/isrc_top.sv
// Pin interface configuration and sub-reset control register bank
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module isrc_top
   import isrc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              i_mclk,
   input  wire logic              i_nrst,
   input  wire logic              i_ce,
   // Register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   // Core status
   input  wire logic              i_sync_mode,
   input  wire logic              i_pll_lock,
   input  wire logic              i_carrier_sense,
   input  wire logic              i_pa_on,
   input  wire logic              i_lna_on,
   input  wire logic              i_rx_data,
   input  wire logic              i_data_clock,
   input  wire logic [N_UNITS-1:0] i_unit_clk_run,
   // Pins
   input  wire logic              i_data_io_pin,
   output logic                   o_data_io_pin,
   output logic                   o_data_io_pin_oe,
   input  wire logic              i_select_pin,
   output logic                   o_lock_pin,
   output logic                   o_data_clock_pin,
   output logic                   o_amp_enable_pin,
   output logic                   o_low_noise_enable_pin,
   // Core controls
   output logic                   o_osc_power_down,
   output logic                   o_ext_clock_select,
   output logic                   o_tx_data,
   output logic                   o_seq_start,
   output logic                   o_test_power_down,
   output logic      [2:0]        o_test_mode,
   output logic      [N_UNITS-1:0] o_unit_rst_low
);

   //------------------------------------------------------------------
   // Registers
   //------------------------------------------------------------------
   logic [7:0] main_reg;
   logic [7:0] next_main_reg;
   logic [7:0] iface;
   logic [7:0] next_iface;
   logic [7:0] seq_reg;
   logic [7:0] next_seq_reg;
   logic [7:0] test_reg;
   logic [7:0] next_test_reg;
   logic [7:0] soft_req;
   logic [7:0] next_rdata;
   isrc_power_down_mode_t power_down_mode;

   isrc_rst_if rst_bus ();

   always_comb begin
      next_main_reg = main_reg;
      next_iface    = iface;
      next_seq_reg  = seq_reg;
      next_test_reg = test_reg;
      soft_req      = '0;
      if (i_wr) begin
         case (i_addr)
            OFS_MAIN:     next_main_reg = i_wdata;
            OFS_IFACE:    next_iface    = i_wdata;
            OFS_SOFT_RST: soft_req      = ~i_wdata;
            OFS_SEQ:      next_seq_reg  = i_wdata;
            OFS_TEST:     next_test_reg = i_wdata;
            default:      ;
         endcase
      end
      if (!main_reg[MAIN_RESET_LOW]) begin
         next_iface    = RST_IFACE;
         next_seq_reg  = RST_SEQ;
         next_test_reg = RST_TEST;
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            OFS_MAIN:     next_rdata = main_reg;
            OFS_IFACE:    next_rdata = iface;
            OFS_SOFT_RST: next_rdata = rst_bus.started;
            OFS_SEQ:      next_rdata = seq_reg;
            OFS_TEST:     next_rdata = test_reg;
            OFS_RST_DONE: next_rdata = rst_bus.done;
            default:      next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         main_reg <= RST_MAIN;
         iface    <= RST_IFACE;
         seq_reg  <= RST_SEQ;
         test_reg <= RST_TEST;
         o_rdata  <= 8'h00;
      end else if (i_ce) begin
         main_reg <= next_main_reg;
         iface    <= next_iface;
         seq_reg  <= next_seq_reg;
         test_reg <= next_test_reg;
         o_rdata  <= next_rdata;
      end
   end

   assign power_down_mode = isrc_power_down_mode_t'(main_reg[MAIN_PD_HI:MAIN_PD_LO]);

   //------------------------------------------------------------------
   // Sub-reset sequencer
   //------------------------------------------------------------------
   assign rst_bus.req      = soft_req;
   assign rst_bus.clk_run  = i_unit_clk_run;
   assign rst_bus.load_all = ~main_reg[MAIN_RESET_LOW];
   assign o_unit_rst_low   = rst_bus.unit_rst_low;

   isrc_subreset u_subreset (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_ce   (i_ce),
      .rst    (rst_bus.unit)
   );

   //------------------------------------------------------------------
   // Pin synchronisers
   //------------------------------------------------------------------
   logic [1:0] sy0;
   logic [1:0] sy1;
   logic [1:0] sy2;
   logic [1:0] pin_lvl;
   logic [1:0] next_pin_lvl;
   logic [1:0] pin_fall;

   always_comb begin
      for (int k = 0; k < 2; k++) begin
         next_pin_lvl[k] = (sy1[k] == sy2[k]) ? sy2[k] : pin_lvl[k];
      end
   end

   assign pin_fall = pin_lvl & ~next_pin_lvl;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sy0     <= 2'h3;
         sy1     <= 2'h3;
         sy2     <= 2'h3;
         pin_lvl <= 2'h3;
      end else if (i_ce) begin
         sy0     <= {i_select_pin, i_data_io_pin};
         sy1     <= sy0;
         sy2     <= sy1;
         pin_lvl <= next_pin_lvl;
      end
   end

   //------------------------------------------------------------------
   // Pin and control outputs
   //------------------------------------------------------------------
   logic       sep;
   logic       gate_lock;
   logic       gate_cs;
   logic       test_en;
   logic       next_dio_oe;
   logic       next_lock_pin;
   logic       next_data_clock_pin;
   logic       next_amp;
   logic       next_lna;
   logic       next_seq_start;
   logic       next_analog_test_power_down;
   logic [2:0] next_test_mode;

   assign sep = iface[IF_SEP_RX_OUT];

   always_comb begin
      next_dio_oe   = ~sep & ~main_reg[MAIN_RXTX];
      next_lock_pin = (sep & i_sync_mode) ? i_rx_data : i_pll_lock;
      gate_lock     = iface[IF_GATE_LOCK] & (power_down_mode == PD_BOTH)
                      & ~i_pll_lock;
      gate_cs       = iface[IF_GATE_CS] & ~i_carrier_sense;
      if (sep & ~i_sync_mode) begin
         next_data_clock_pin = i_rx_data;
      end else if (i_sync_mode & (gate_lock | gate_cs)) begin
         next_data_clock_pin = 1'b1;
      end else begin
         next_data_clock_pin = i_data_clock;
      end
      next_amp = iface[IF_AMP_CTRL]
                 ? (i_pa_on ? iface[IF_AMP_POL] : ~iface[IF_AMP_POL])
                 : iface[IF_AMP_POL];
      next_lna = iface[IF_LNA_CTRL]
                 ? (i_lna_on ? iface[IF_LNA_POL] : ~iface[IF_LNA_POL])
                 : iface[IF_LNA_POL];
      test_en = test_reg[TEST_FILTER_EN] | test_reg[TEST_ANALOG_EN];
      next_analog_test_power_down   = test_en ? iface[IF_ANALOG_TEST_POWER_DOWN] : ANALOG_TEST_POWER_DOWN_IDLE;
      next_test_mode = test_en ? iface[IF_TEST_MD_HI:IF_TEST_MD_LO]
                               : TEST_MODE_IDLE;
      next_seq_start = (power_down_mode == PD_AUTO)
                       & (seq_reg[SEQ_SELECT_SRC] ? pin_fall[1]
                          : (sep & pin_fall[0]));
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_data_io_pin          <= 1'b0;
         o_data_io_pin_oe       <= 1'b0;
         o_lock_pin             <= 1'b0;
         o_data_clock_pin       <= 1'b0;
         o_amp_enable_pin       <= 1'b0;
         o_low_noise_enable_pin <= 1'b0;
         o_seq_start            <= 1'b0;
         o_test_power_down      <= ANALOG_TEST_POWER_DOWN_IDLE;
         o_test_mode            <= TEST_MODE_IDLE;
      end else if (i_ce) begin
         o_data_io_pin          <= i_rx_data;
         o_data_io_pin_oe       <= next_dio_oe;
         o_lock_pin             <= next_lock_pin;
         o_data_clock_pin       <= next_data_clock_pin;
         o_amp_enable_pin       <= next_amp;
         o_low_noise_enable_pin <= next_lna;
         o_seq_start            <= next_seq_start;
         o_test_power_down      <= next_analog_test_power_down;
         o_test_mode            <= next_test_mode;
      end
   end

   assign o_osc_power_down   = iface[IF_OSC_BYPASS];
   assign o_ext_clock_select = iface[IF_OSC_BYPASS];
   assign o_tx_data          = pin_lvl[0];

   //------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------
   a_amp_pin_level: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && iface[IF_AMP_CTRL] && i_pa_on)
      |=> (o_amp_enable_pin == $past(iface[IF_AMP_POL]))
   ) else $error("Amp pin not at active level with amp on");

   a_lna_pin_fixed: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && !iface[IF_LNA_CTRL])
      |=> (o_low_noise_enable_pin == $past(iface[IF_LNA_POL]))
   ) else $error("LNA pin differs from polarity bit");

   a_test_idle_val: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && test_reg[TEST_FILTER_EN:TEST_ANALOG_EN] == 2'h0)
      |=> (o_test_power_down && o_test_mode == TEST_MODE_IDLE)
   ) else $error("Test outputs not at idle values");

   a_data_clock_pin_gate_lock: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && i_sync_mode && iface[IF_GATE_LOCK]
       && power_down_mode == PD_BOTH && !i_pll_lock)
      |=> o_data_clock_pin
   ) else $error("Data clock not held high without lock");

   a_data_clock_pin_gate_cs: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && i_sync_mode && iface[IF_GATE_CS] && !i_carrier_sense)
      |=> o_data_clock_pin
   ) else $error("Data clock not held high without carrier");

   a_dio_separate: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && sep) |=> !o_data_io_pin_oe
   ) else $error("Data pin driven in separate mode");

   a_seq_needs_auto: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      o_seq_start |-> $past(power_down_mode == PD_AUTO)
   ) else $error("Sequence start outside automatic mode");

   a_main_rst_load: assert property (
      @(posedge i_mclk) disable iff (!i_nrst)
      (i_ce && !main_reg[MAIN_RESET_LOW])
      |=> (iface == RST_IFACE && seq_reg == RST_SEQ && test_reg == RST_TEST)
   ) else $error("Defaults not loaded under main reset");

endmodule : isrc_top

// ===== tb/isrc_host_model.sv
// Host microcontroller model: register bus master and pin drivers
`timescale 1ns/1ns
module isrc_host_model
   import isrc_pkg::*;
(
   // Clock
   input  wire logic              i_mclk,
   // Register port
   output logic      [ADDR_W-1:0] o_addr,
   output logic      [DATA_W-1:0] o_wdata,
   output logic                   o_wr,
   output logic                   o_rd,
   input  wire logic [DATA_W-1:0] i_rdata,
   // Pins
   input  wire logic              i_dio_out,
   input  wire logic              i_dio_oe,
   output logic                   o_dio,
   output logic                   o_select_pin
);
   logic host_dio;

   initial begin
      o_addr       = '0;
      o_wdata      = '0;
      o_wr         = 1'b0;
      o_rd         = 1'b0;
      host_dio     = 1'b1;
      o_select_pin = 1'b1;
   end

   // Host drives the data pin only while the device has let go
   assign o_dio = i_dio_oe ? i_dio_out : host_dio;

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= 1'b1;
      @(posedge i_mclk);
      o_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_mclk);
      o_rd   <= 1'b0;
      @(posedge i_mclk);
      d = i_rdata;
   endtask : rd

   // Poll the done status until every unit reports finished
   task automatic poll_done(output logic ok);
      logic [7:0] d;
      ok = 1'b0;
      for (int n = 0; n < 16 && !ok; n++) begin
         rd(OFS_RST_DONE, d);
         ok = (d === 8'hFF);
      end
   endtask : poll_done

   task automatic pins(input logic data_io_pin, input logic sel);
      @(posedge i_mclk);
      host_dio     <= data_io_pin;
      o_select_pin <= sel;
   endtask : pins
endmodule : isrc_host_model

// ===== tb/test_interface_and_subreset_control.sv
// Self-checking bench of the interface and sub-reset control block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
   begin \
      comparisons++; \
      if ((ex) !== (gt)) begin \
         miscompares++; \
         $display("unexpected %s expected %h seen %h", nm, ex, gt); \
      end \
   end
module test_interface_and_subreset_control;
   import isrc_pkg::*;
   logic i_mclk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1;
   logic [7:0] i_addr, i_wdata, o_rdata, i_unit_clk_run = 8'h00;
   logic [7:0] o_unit_rst_low, exp_v, ifc, mn, seen;
   logic i_wr, i_rd, rd_seen = 1'b0, ok, dio_wire, i_select_pin;
   logic i_sync_mode = 0, i_pll_lock = 0, i_carrier_sense = 0;
   logic i_pa_on = 0, i_lna_on = 0, i_rx_data = 0, i_data_clock = 0;
   logic o_data_io_pin, o_data_io_pin_oe, o_lock_pin, o_data_clock_pin;
   logic o_amp_enable_pin, o_low_noise_enable_pin, o_osc_power_down;
   logic o_ext_clock_select, o_tx_data, o_seq_start, o_test_power_down;
   logic [2:0] o_test_mode;
   logic [1:0] tst;
   logic [31:0] r = 32'h0000_4302;
   logic [7:0] exp_q [$];
   int miscompares = 0, comparisons = 0, cycles = 0, pulses;
   logic [1:0] seq_pd [4] = '{2'b11, 2'b10, 2'b11, 2'b11};
   logic [7:0] seq_reg [4] = '{8'h0A, 8'h0A, 8'h8A, 8'h8A};
   logic seq_sel [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   int seq_exp [4] = '{1, 0, 0, 1};

   isrc_top isrc_top_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_sync_mode(i_sync_mode), .i_pll_lock(i_pll_lock),
      .i_carrier_sense(i_carrier_sense), .i_pa_on(i_pa_on),
      .i_lna_on(i_lna_on), .i_rx_data(i_rx_data),
      .i_data_clock(i_data_clock), .i_unit_clk_run(i_unit_clk_run),
      .i_data_io_pin(dio_wire), .o_data_io_pin(o_data_io_pin),
      .o_data_io_pin_oe(o_data_io_pin_oe), .i_select_pin(i_select_pin),
      .o_lock_pin(o_lock_pin), .o_data_clock_pin(o_data_clock_pin),
      .o_amp_enable_pin(o_amp_enable_pin),
      .o_low_noise_enable_pin(o_low_noise_enable_pin),
      .o_osc_power_down(o_osc_power_down),
      .o_ext_clock_select(o_ext_clock_select), .o_tx_data(o_tx_data),
      .o_seq_start(o_seq_start), .o_test_power_down(o_test_power_down),
      .o_test_mode(o_test_mode), .o_unit_rst_low(o_unit_rst_low));

   isrc_host_model host_inst (.i_mclk(i_mclk), .o_addr(i_addr),
      .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd), .i_rdata(o_rdata),
      .i_dio_out(o_data_io_pin), .i_dio_oe(o_data_io_pin_oe),
      .o_dio(dio_wire), .o_select_pin(i_select_pin));

   always #2 i_mclk = ~i_mclk;

   //------------------------------------------------------------------
   // Read data watcher and timeout
   //------------------------------------------------------------------
   always @(posedge i_mclk) begin
      if (rd_seen && exp_q.size() > 0) begin
         exp_v = exp_q.pop_front();
         `CHK("read data", exp_v, o_rdata)
      end
      rd_seen <= i_rd;
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         test_done();
      end
   end

   task automatic test_done();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      exp_q.push_back(e);
      host_inst.rd(a, d);
   endtask : rd_exp

   task automatic check_pins();
      logic sep;
      logic e;
      sep = ifc[IF_SEP_RX_OUT];
      `CHK("osc power down", ifc[IF_OSC_BYPASS], o_osc_power_down)
      `CHK("ext clock", ifc[IF_OSC_BYPASS], o_ext_clock_select)
      `CHK("dio oe", !sep && !mn[MAIN_RXTX], o_data_io_pin_oe)
      if (!sep && !mn[MAIN_RXTX]) `CHK("dio", i_rx_data, dio_wire)
      if (sep && i_sync_mode) `CHK("lock pin", i_rx_data, o_lock_pin)
      else `CHK("lock pin", i_pll_lock, o_lock_pin)
      e = i_data_clock;
      if (sep && !i_sync_mode) e = i_rx_data;
      else if (i_sync_mode && ifc[IF_GATE_LOCK] && mn[5:4] == PD_BOTH
               && !i_pll_lock) e = 1'b1;
      else if (i_sync_mode && ifc[IF_GATE_CS] && !i_carrier_sense)
         e = 1'b1;
      `CHK("data clock", e, o_data_clock_pin)
      if (tst == 2'b00) begin
         e = ifc[IF_AMP_CTRL] ? (i_pa_on ~^ ifc[1]) : ifc[1];
         `CHK("amp pin", e, o_amp_enable_pin)
         e = ifc[IF_LNA_CTRL] ? (i_lna_on ~^ ifc[0]) : ifc[0];
         `CHK("lna pin", e, o_low_noise_enable_pin)
         `CHK("analog_test_power_down", ANALOG_TEST_POWER_DOWN_IDLE, o_test_power_down)
         `CHK("test mode", TEST_MODE_IDLE, o_test_mode)
      end else begin
         `CHK("analog_test_power_down", ifc[IF_ANALOG_TEST_POWER_DOWN], o_test_power_down)
         `CHK("test mode", ifc[2:0], o_test_mode)
      end
   endtask : check_pins

   //------------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge i_mclk);
      i_nrst <= 1'b1;
      rd_exp(OFS_IFACE, RST_IFACE);
      rd_exp(OFS_SEQ, RST_SEQ);
      rd_exp(OFS_TEST, RST_TEST);
      rd_exp(OFS_SOFT_RST, RST_SOFT_RST);
      rd_exp(OFS_RST_DONE, 8'h00);
      rd_exp(8'h55, 8'h00);
      `CHK("unit reset", 8'hFF, o_unit_rst_low)
      i_unit_clk_run <= 8'hFF;
      host_inst.poll_done(ok);
      `CHK("done poll", 1'b1, ok)
      rd_exp(OFS_SOFT_RST, 8'hFF);
      for (int i = 0; i < N_UNITS; i++) begin
         host_inst.wr(OFS_SOFT_RST, ~(8'h01 << i));
         seen = 8'hFF;
         for (int n = 0; n < 6 && seen === 8'hFF; n++) begin
            @(posedge i_mclk);
            seen = o_unit_rst_low;
         end
         `CHK("unit reset", ~(8'h01 << i), seen)
         host_inst.poll_done(ok);
         `CHK("done poll", 1'b1, ok)
      end
      i_unit_clk_run <= 8'hF7;
      host_inst.wr(OFS_SOFT_RST, 8'hF7);
      repeat (8) @(posedge i_mclk);
      `CHK("unit reset", 8'hFF, o_unit_rst_low)
      rd_exp(OFS_SOFT_RST, 8'hF7);
      i_unit_clk_run <= 8'hFF;
      host_inst.poll_done(ok);
      `CHK("done poll", 1'b1, ok)
      host_inst.wr(OFS_SOFT_RST, 8'hFB);
      @(posedge i_mclk);
      i_unit_clk_run <= 8'hFB;
      repeat (4) @(posedge i_mclk);
      `CHK("unit reset", 8'hFB, o_unit_rst_low)
      i_unit_clk_run <= 8'hFF;
      host_inst.poll_done(ok);
      `CHK("done poll", 1'b1, ok)
      rd_exp(OFS_SOFT_RST, 8'hFF);
      for (int k = 0; k < 24; k++) begin
         r = lfsr(r);
         tst = 2'(k % 3);
         mn = {r[8], 1'b0, r[10:9], 4'h1};
         ifc = r[7:0];
         if (mn[MAIN_RXTX]) ifc[IF_GATE_CS] = 1'b0;
         host_inst.wr(OFS_TEST, {6'h00, tst});
         host_inst.wr(OFS_MAIN, mn);
         host_inst.wr(OFS_IFACE, ifc);
         @(posedge i_mclk);
         {i_sync_mode, i_pll_lock, i_carrier_sense, i_pa_on, i_lna_on,
          i_rx_data, i_data_clock} <= r[22:16];
         repeat (3) @(posedge i_mclk);
         #1;
         check_pins();
         rd_exp(OFS_IFACE, ifc);
      end
      host_inst.wr(OFS_TEST, 8'h00);
      for (int c = 0; c < 4; c++) begin
         host_inst.wr(OFS_MAIN, {2'b00, seq_pd[c], 4'h1});
         host_inst.wr(OFS_SEQ, seq_reg[c]);
         host_inst.wr(OFS_IFACE, 8'h40);
         host_inst.pins(1'b1, 1'b1);
         repeat (8) @(posedge i_mclk);
         host_inst.pins(seq_sel[c], !seq_sel[c]);
         pulses = 0;
         repeat (16) @(posedge i_mclk) pulses += int'(o_seq_start);
         `CHK("sequence starts", seq_exp[c], pulses)
         `CHK("tx data", seq_sel[c], o_tx_data)
      end
      host_inst.wr(OFS_IFACE, 8'hFF);
      host_inst.wr(OFS_MAIN, 8'h00);
      rd_exp(OFS_IFACE, RST_IFACE);
      rd_exp(OFS_SEQ, RST_SEQ);
      rd_exp(OFS_MAIN, 8'h00);
      host_inst.wr(OFS_MAIN, RST_MAIN);
      host_inst.wr(OFS_IFACE, 8'h12);
      rd_exp(OFS_IFACE, 8'h12);
      test_done();
   end
endmodule : test_interface_and_subreset_control
